// ==== inc/biu_cfg.svh ====
`ifndef XFER_CFG_SVH
`define XFER_CFG_SVH

// bus transfer encodings
`define TRANS_IDLE   2'h0
`define TRANS_NONSEQ 2'h2
`define TRANS_SEQ    2'h3
`define BURST_SINGLE 3'h0
`define BURST_WRAP8  3'h4
`define BURST_INCR4  3'h3
`define BURST_INCR8  3'h5
`define SIZE_BYTE    3'h0
`define SIZE_HALF    3'h1
`define SIZE_WORD    3'h2

// core request kinds
`define KIND_READ    3'h0
`define KIND_WRITE   3'h1
`define KIND_WALK    3'h2
`define KIND_FETCH   3'h3
`define KIND_PREF    3'h4
`define KIND_FILL    3'h5
`define KIND_WBACK   3'h6
`define KIND_BWRITE  3'h7

// line geometry
`define LINE_WORDS   4'h8
`define HALF_WORDS   4'h4
`define ONE_WORD     4'h1
`define HALF_OFFSET  32'h10
`define HALF_INDEX   3'h4
`define DIRTY_NONE   2'h0
`define DIRTY_LOW    2'h1
`define DIRTY_HIGH   2'h2
`define DIRTY_BOTH   2'h3

`endif

// ==== inc/biu_pkg.sv ====
package xfer_pkg;
	typedef enum logic {st_idle, st_run} state_t;
endpackage : xfer_pkg

// ==== design/beat_addr_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "biu_cfg.svh"

module beat_addr_gen (
	// transfer description
	input  wire logic [31:0] base,
	input  wire logic [2:0]  beat,
	input  wire logic [2:0]  burst,
	input  wire logic [2:0]  size,
	// generated address
	output logic      [31:0] addr,
	output logic             misaligned
);
	always_comb begin
		if (burst == `BURST_WRAP8) begin
			addr = {base[31:5], 3'(base[4:2] + beat), 2'h0};
		end else if (burst != `BURST_SINGLE) begin
			addr = {base[31:2], 2'h0} + {27'h0, beat, 2'h0};
		end else if (size == `SIZE_WORD) begin
			addr = {base[31:2], 2'h0};
		end else if (size == `SIZE_HALF) begin
			addr = {base[31:1], 1'b0};
		end else begin
			addr = base;
		end
		misaligned = (size == `SIZE_HALF && base[0])
			|| (size == `SIZE_WORD && base[1:0] != 2'h0);
	end
endmodule : beat_addr_gen
`default_nettype wire

// ==== design/core_ahb_bus_interface.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "biu_cfg.svh"

module core_ahb_bus_interface (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         ce,
	// core request
	input  wire logic         req_valid,
	output logic              req_ready,
	input  wire logic [2:0]   req_kind,
	input  wire logic [31:0]  req_addr,
	input  wire logic [2:0]   req_size,
	input  wire logic [3:0]   req_words,
	input  wire logic [1:0]   req_dirty,
	input  wire logic         req_narrow,
	input  wire logic         prefetch_en,
	input  wire logic [255:0] wr_line,
	// core answer
	output logic              rd_valid,
	output logic [31:0]       rd_data,
	output logic [2:0]        rd_idx,
	output logic              rd_pair,
	output logic              done,
	output logic              bus_err,
	output logic              align_fault,
	// bus master
	output logic [31:0]       haddr,
	output logic [1:0]        htrans,
	output logic              hwrite,
	output logic [2:0]        hsize,
	output logic [2:0]        hburst,
	output logic [31:0]       hwdata,
	input  wire logic         hready,
	input  wire logic         hresp,
	input  wire logic [31:0]  hrdata
);
	xfer_pkg::state_t st_r, st_nxt;
	logic [2:0]  kind_r, kind_nxt, burst_r, burst_nxt, size_r, size_nxt;
	logic [1:0]  dirty_r, dirty_nxt, htrans_r, htrans_nxt;
	logic [31:0] base_r, base_nxt, haddr_r, haddr_nxt, hwdata_r, hwdata_nxt;
	logic [2:0]  cb_r, cb_nxt, widx_r, widx_nxt, didx_r, didx_nxt;
	logic [3:0]  cl_r, cl_nxt, rem_r, rem_nxt, len;
	logic [2:0]  hsize_r, hsize_nxt, hburst_r, hburst_nxt, rd_idx_r, rd_idx_nxt;
	logic [31:0] rd_data_r, rd_data_nxt;
	logic        narrow_r, narrow_nxt, hwrite_r, hwrite_nxt, dph_r, dph_nxt;
	logic        dwr_r, dwr_nxt, dlast_r, dlast_nxt, ready_r, ready_nxt;
	logic        rd_valid_r, rd_valid_nxt, rd_pair_r, rd_pair_nxt;
	logic        done_r, done_nxt, err_r, err_nxt, fault_r, fault_nxt;
	logic [31:0] g_base, g_addr;
	logic [2:0]  g_beat, g_burst, g_size;
	logic        g_mis, load, acc, fin;

	// split a word count into the largest legal chunk
	function automatic logic [3:0] chunk_len(input logic [3:0] n);
		if (n >= `LINE_WORDS) chunk_len = `LINE_WORDS;
		else if (n >= `HALF_WORDS) chunk_len = `HALF_WORDS;
		else chunk_len = `ONE_WORD;
	endfunction : chunk_len

	function automatic logic [2:0] burst_of(input logic [3:0] n);
		if (n == `LINE_WORDS) burst_of = `BURST_INCR8;
		else if (n == `HALF_WORDS) burst_of = `BURST_INCR4;
		else burst_of = `BURST_SINGLE;
	endfunction : burst_of

	beat_addr_gen u_gen (
		.base       (g_base),
		.beat       (g_beat),
		.burst      (g_burst),
		.size       (g_size),
		.addr       (g_addr),
		.misaligned (g_mis)
	);

	always_comb begin
		st_nxt = st_r; kind_nxt = kind_r; dirty_nxt = dirty_r;
		narrow_nxt = narrow_r; base_nxt = base_r; burst_nxt = burst_r;
		size_nxt = size_r; cb_nxt = cb_r; cl_nxt = cl_r; rem_nxt = rem_r;
		widx_nxt = widx_r; didx_nxt = didx_r; dph_nxt = dph_r;
		dwr_nxt = dwr_r; dlast_nxt = dlast_r; ready_nxt = ready_r;
		htrans_nxt = htrans_r; hwrite_nxt = hwrite_r; hsize_nxt = hsize_r;
		hburst_nxt = hburst_r; hwdata_nxt = hwdata_r;
		rd_data_nxt = rd_data_r; rd_idx_nxt = rd_idx_r; rd_pair_nxt = rd_pair_r;
		rd_valid_nxt = 1'b0; done_nxt = 1'b0; err_nxt = err_r;
		fault_nxt = fault_r; load = 1'b0; len = `ONE_WORD;
		g_base = base_r; g_beat = cb_r; g_burst = burst_r; g_size = size_r;
		acc = htrans_r != `TRANS_IDLE && hready;
		fin = dph_r && hready;
		if (fin) begin
			dph_nxt = 1'b0;
			if (!dwr_r) begin
				rd_valid_nxt = 1'b1;
				rd_data_nxt = hrdata;
				rd_idx_nxt = didx_r;
				rd_pair_nxt = narrow_r && (kind_r == `KIND_FETCH
					|| kind_r == `KIND_PREF);
			end
			// an error beat is only recorded; no split or retry exists
			if (hresp) err_nxt = 1'b1;
			if (dlast_r) begin
				done_nxt = 1'b1;
				st_nxt = xfer_pkg::st_idle;
				ready_nxt = 1'b1;
			end
		end
		if (acc) begin
			dph_nxt = 1'b1;
			dwr_nxt = hwrite_r;
			didx_nxt = haddr_r[4:2];
			hwdata_nxt = hwrite_r ? wr_line[32*widx_r +: 32] : 32'h0;
			dlast_nxt = 4'({1'b0, cb_r} + 4'h1) == cl_r && rem_r == 4'h0;
			if (4'({1'b0, cb_r} + 4'h1) < cl_r) begin
				cb_nxt = 3'(cb_r + 3'h1);
				widx_nxt = 3'(widx_r + 3'h1);
				htrans_nxt = `TRANS_SEQ;
				g_beat = cb_nxt;
				load = 1'b1;
			end else if (rem_r != 4'h0) begin
				len = chunk_len(rem_r);
				cl_nxt = len;
				rem_nxt = 4'(rem_r - len);
				base_nxt = base_r + {26'h0, cl_r, 2'h0};
				burst_nxt = burst_of(len);
				cb_nxt = 3'h0;
				widx_nxt = 3'(widx_r + 3'h1);
				htrans_nxt = `TRANS_NONSEQ;
				hburst_nxt = burst_nxt;
				g_base = base_nxt; g_beat = 3'h0; g_burst = burst_nxt;
				load = 1'b1;
			end else begin
				htrans_nxt = `TRANS_IDLE;
			end
		end
		if (st_r == xfer_pkg::st_idle && req_valid && ready_r) begin
			kind_nxt = req_kind; dirty_nxt = req_dirty;
			narrow_nxt = req_narrow; err_nxt = 1'b0;
			base_nxt = req_addr; cb_nxt = 3'h0; widx_nxt = 3'h0;
			cl_nxt = `ONE_WORD; rem_nxt = 4'h0;
			burst_nxt = `BURST_SINGLE; size_nxt = `SIZE_WORD;
			hwrite_nxt = 1'b0;
			case (req_kind)
				`KIND_READ: size_nxt = req_size;
				`KIND_WRITE: begin
					size_nxt = req_size;
					hwrite_nxt = 1'b1;
				end
				`KIND_PREF: if (prefetch_en) begin
					cl_nxt = `HALF_WORDS;
					burst_nxt = `BURST_INCR4;
				end
				`KIND_FILL: begin
					cl_nxt = `LINE_WORDS;
					burst_nxt = `BURST_WRAP8;
				end
				`KIND_WBACK: begin
					hwrite_nxt = 1'b1;
					base_nxt = {req_addr[31:5], 5'h0};
					cl_nxt = req_dirty == `DIRTY_BOTH ? `LINE_WORDS : `HALF_WORDS;
					burst_nxt = burst_of(cl_nxt);
					if (req_dirty == `DIRTY_HIGH) begin
						base_nxt = base_nxt + `HALF_OFFSET;
						widx_nxt = `HALF_INDEX;
					end
				end
				`KIND_BWRITE: begin
					hwrite_nxt = 1'b1;
					len = req_words == 4'h0 ? `ONE_WORD
						: req_words > `LINE_WORDS ? `LINE_WORDS : req_words;
					cl_nxt = chunk_len(len);
					rem_nxt = 4'(len - cl_nxt);
					burst_nxt = burst_of(cl_nxt);
				end
				default: ; // walk and fetch: single word
			endcase
			g_base = base_nxt; g_beat = 3'h0;
			g_burst = burst_nxt; g_size = size_nxt;
			fault_nxt = g_mis;
			hsize_nxt = size_nxt;
			hburst_nxt = burst_nxt;
			if (req_kind == `KIND_WBACK && req_dirty == `DIRTY_NONE) begin
				done_nxt = 1'b1; // clean line, nothing to write
			end else begin
				st_nxt = xfer_pkg::st_run;
				ready_nxt = 1'b0;
				htrans_nxt = `TRANS_NONSEQ;
				load = 1'b1;
			end
		end
		haddr_nxt = load ? g_addr : haddr_r;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= xfer_pkg::st_idle; kind_r <= `KIND_READ;
			dirty_r <= `DIRTY_NONE; narrow_r <= 1'b0; base_r <= 32'h0;
			burst_r <= `BURST_SINGLE; size_r <= `SIZE_WORD; cb_r <= 3'h0;
			cl_r <= `ONE_WORD; rem_r <= 4'h0; widx_r <= 3'h0; didx_r <= 3'h0;
			dph_r <= 1'b0; dwr_r <= 1'b0; dlast_r <= 1'b0; ready_r <= 1'b1;
			haddr_r <= 32'h0; htrans_r <= `TRANS_IDLE; hwrite_r <= 1'b0;
			hsize_r <= `SIZE_WORD; hburst_r <= `BURST_SINGLE;
			hwdata_r <= 32'h0; rd_data_r <= 32'h0; rd_idx_r <= 3'h0;
			rd_pair_r <= 1'b0; rd_valid_r <= 1'b0; done_r <= 1'b0;
			err_r <= 1'b0; fault_r <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt; kind_r <= kind_nxt; dirty_r <= dirty_nxt;
			narrow_r <= narrow_nxt; base_r <= base_nxt; burst_r <= burst_nxt;
			size_r <= size_nxt; cb_r <= cb_nxt; cl_r <= cl_nxt;
			rem_r <= rem_nxt; widx_r <= widx_nxt; didx_r <= didx_nxt;
			dph_r <= dph_nxt; dwr_r <= dwr_nxt; dlast_r <= dlast_nxt;
			ready_r <= ready_nxt; haddr_r <= haddr_nxt;
			htrans_r <= htrans_nxt; hwrite_r <= hwrite_nxt;
			hsize_r <= hsize_nxt; hburst_r <= hburst_nxt;
			hwdata_r <= hwdata_nxt; rd_data_r <= rd_data_nxt;
			rd_idx_r <= rd_idx_nxt; rd_pair_r <= rd_pair_nxt;
			rd_valid_r <= rd_valid_nxt; done_r <= done_nxt;
			err_r <= err_nxt; fault_r <= fault_nxt;
		end
	end

	assign req_ready = ready_r; assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r; assign rd_idx = rd_idx_r;
	assign rd_pair = rd_pair_r; assign done = done_r;
	assign bus_err = err_r; assign align_fault = fault_r;
	assign haddr = haddr_r; assign htrans = htrans_r;
	assign hwrite = hwrite_r; assign hsize = hsize_r;
	assign hburst = hburst_r; assign hwdata = hwdata_r;

	a_burst_code_legal: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r != `TRANS_IDLE |-> hburst_r == `BURST_SINGLE
		|| hburst_r == `BURST_INCR4 || hburst_r == `BURST_INCR8
		|| hburst_r == `BURST_WRAP8)
		else $error("illegal burst kind");
	a_chunk_matches_burst: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r == `TRANS_NONSEQ && hburst_r != `BURST_SINGLE
		|-> cl_r == `HALF_WORDS || cl_r == `LINE_WORDS)
		else $error("burst chunk length wrong");
	a_single_cases: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r == `TRANS_NONSEQ && (kind_r == `KIND_READ
		|| kind_r == `KIND_WRITE || kind_r == `KIND_WALK
		|| kind_r == `KIND_FETCH) |-> hburst_r == `BURST_SINGLE)
		else $error("uncached access not single");
	a_half_writeback: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r == `TRANS_NONSEQ && kind_r == `KIND_WBACK
		&& dirty_r != `DIRTY_BOTH |-> hburst_r == `BURST_INCR4)
		else $error("half write-back not four beats");
	a_full_writeback: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r == `TRANS_NONSEQ && kind_r == `KIND_WBACK
		&& dirty_r == `DIRTY_BOTH |-> hburst_r == `BURST_INCR8)
		else $error("full write-back not eight beats");
	a_fill_wraps: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r == `TRANS_NONSEQ && kind_r == `KIND_FILL
		|-> hburst_r == `BURST_WRAP8
		&& haddr_r[31:2] == base_r[31:2])
		else $error("fill not wrap8 from missed word");
	a_fetch_word: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r != `TRANS_IDLE && (kind_r == `KIND_FETCH
		|| kind_r == `KIND_PREF) |-> hsize_r == `SIZE_WORD)
		else $error("fetch not word sized");
	a_addr_aligned: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r != `TRANS_IDLE |-> (hsize_r != `SIZE_HALF || !haddr_r[0])
		&& (hsize_r != `SIZE_WORD || haddr_r[1:0] == 2'h0))
		else $error("address not aligned");
	a_addr_held: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r != `TRANS_IDLE && !hready |=> $stable(haddr_r)
		&& $stable(htrans_r))
		else $error("address phase dropped while stalled");
	a_burst_word_size: assert property (
		@(posedge clock) disable iff (!rst_b)
		htrans_r != `TRANS_IDLE && hburst_r != `BURST_SINGLE
		|-> hsize_r == `SIZE_WORD)
		else $error("burst not word sized");
	a_pair_on_fetch: assert property (
		@(posedge clock) disable iff (!rst_b)
		rd_valid_r && narrow_r && kind_r == `KIND_FETCH |-> rd_pair_r)
		else $error("compressed fetch not paired");
	c_fill_done: cover property (@(posedge clock) disable iff (!rst_b)
		done_r && kind_r == `KIND_FILL);
	c_full_writeback: cover property (@(posedge clock) disable iff (!rst_b)
		done_r && kind_r == `KIND_WBACK && dirty_r == `DIRTY_BOTH);
	c_split_write: cover property (@(posedge clock) disable iff (!rst_b)
		htrans_r == `TRANS_NONSEQ && kind_r == `KIND_BWRITE
		&& cb_r == 3'h0 && widx_r != 3'h0);
endmodule : core_ahb_bus_interface
`default_nettype wire

// ==== tb/ahb_slave_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module ahb_slave_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// master side of the layer
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	// wait states for the next data phase
	input  wire logic [1:0]  wait_len,
	// slave answer
	output logic             hready,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	logic        dp_r;
	logic        dw_r;
	logic [31:0] da_r;
	logic [1:0]  wait_r;
	logic [31:0] junk_r;

	// only master on this slave: no clash, so only commanded waits stall
	assign hready = !dp_r || (wait_r == 2'h0);
	assign hresp  = 1'b0;
	// off a completing read beat the lines move, so a late sample fails
	assign hrdata = (dp_r && !dw_r && hready) ?
		{~da_r[15:2], 2'h3, da_r[15:2], 2'h0} : junk_r;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dp_r   <= 1'b0;
			dw_r   <= 1'b0;
			da_r   <= 32'h0;
			wait_r <= 2'h0;
			junk_r <= 32'h1;
		end else begin
			junk_r <= {junk_r[30:0], ~(junk_r[31] ^ junk_r[21])};
			if (hready) begin
				dp_r   <= htrans[1];
				dw_r   <= hwrite;
				da_r   <= haddr;
				wait_r <= wait_len;
			end else begin
				wait_r <= wait_r - 2'h1;
			end
		end
	end
endmodule : ahb_slave_model

`default_nettype wire

// ==== tb/core_ahb_bus_interface_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "biu_cfg.svh"

module core_ahb_bus_interface_test;
	logic         clock, rst_b, ce, req_valid, req_ready, req_narrow;
	logic         prefetch_en, rd_valid, rd_pair, done, bus_err;
	logic         align_fault, hwrite, hready, hresp, dph, dwr, cur_pair;
	logic [2:0]   req_kind, req_size, rd_idx, hsize, hburst;
	logic [1:0]   req_dirty, htrans, wait_len;
	logic [3:0]   req_words;
	logic [31:0]  req_addr, rd_data, haddr, hwdata, hrdata, dad, cur_addr;
	logic [255:0] wr_line;
	logic [31:0]  ea[$];
	logic [7:0]   eb[$];
	logic [40:0]  aq[$];
	logic [63:0]  wq[$];
	int           errors, comparisons, seed, rd_cnt;

	core_ahb_bus_interface u_dut (.clock, .rst_b, .ce, .req_valid,
		.req_ready, .req_kind, .req_addr, .req_size, .req_words, .req_dirty,
		.req_narrow, .prefetch_en, .wr_line, .rd_valid, .rd_data, .rd_idx,
		.rd_pair, .done, .bus_err, .align_fault, .haddr, .htrans, .hwrite,
		.hsize, .hburst, .hwdata, .hready, .hresp, .hrdata);
	ahb_slave_model u_slave (.clock, .rst_b, .haddr, .htrans, .hwrite,
		.wait_len, .hready, .hresp, .hrdata);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [31:0] mem(logic [31:0] a);
		return {~a[15:0], a[15:0]};
	endfunction : mem

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	// expected beats of one chunk: address and {burst, size, trans}
	task automatic add(logic [31:0] a, logic [2:0] b, logic [2:0] s, int n,
		bit wrap);
		for (int k = 0; k < n; k++) begin
			if (wrap)
				ea.push_back({a[31:5], a[4:2] + 3'(k), 2'h0});
			else
				ea.push_back(a + 32'(4 * k));
			eb.push_back({b, s, (k == 0) ? `TRANS_NONSEQ : `TRANS_SEQ});
		end
	endtask : add

	// bus monitor: address phases, completed write beats, read beats
	always @(posedge clock) begin
		if (rst_b && ce && hready) begin
			if (dph && dwr)
				wq.push_back({dad, hwdata});
			dph = htrans[1];
			dwr = hwrite;
			dad = haddr;
			if (htrans[1])
				aq.push_back({hwrite, haddr, hburst, hsize, htrans});
		end
		if (rst_b && rd_valid) begin
			// the first word handed back must be the one that was asked for
			if (rd_cnt == 0)
				chk("rd_idx", {29'h0, cur_addr[4:2]}, {29'h0, rd_idx});
			rd_cnt++;
			chk("rd_data", mem({cur_addr[31:5], rd_idx, 2'h0}), rd_data);
			chk("rd_pair", {31'h0, cur_pair}, {31'h0, rd_pair});
		end
	end

	task automatic run(logic [2:0] k, logic [31:0] a);
		int n;
		int c;
		logic [31:0] p;
		logic [31:0] s;
		logic [31:0] w;
		@(negedge clock);
		ea.delete();
		eb.delete();
		aq.delete();
		wq.delete();
		rd_cnt = 0;
		p = {a[31:2], 2'h0};
		s = (req_size == `SIZE_HALF) ? {a[31:1], 1'b0} : p;
		if (req_size == `SIZE_BYTE)
			s = a;
		case (k)
		`KIND_READ, `KIND_WRITE: add(s, `BURST_SINGLE, req_size, 1, 0);
		`KIND_WALK, `KIND_FETCH: add(p, `BURST_SINGLE, `SIZE_WORD, 1, 0);
		`KIND_PREF: begin
			if (prefetch_en)
				add(p, `BURST_INCR4, `SIZE_WORD, 4, 0);
			else
				add(p, `BURST_SINGLE, `SIZE_WORD, 1, 0);
		end
		`KIND_FILL: add(p, `BURST_WRAP8, `SIZE_WORD, 8, 1);
		`KIND_WBACK: begin
			w = {a[31:5], 5'h0};
			if (req_dirty == `DIRTY_BOTH)
				add(w, `BURST_INCR8, `SIZE_WORD, 8, 0);
			else if (req_dirty != `DIRTY_NONE)
				add(w + (req_dirty[1] ? `HALF_OFFSET : 32'h0), `BURST_INCR4,
					`SIZE_WORD, 4, 0);
		end
		default: begin
			n = (req_words == 4'h0) ? 1 : (req_words > 4'h8) ? 8 : req_words;
			w = p;
			while (n > 0) begin
				c = (n >= 8) ? 8 : (n >= 4) ? 4 : 1;
				add(w, (c == 8) ? `BURST_INCR8 : (c == 4) ? `BURST_INCR4 :
					`BURST_SINGLE, `SIZE_WORD, c, 0);
				w = w + 32'(4 * c);
				n = n - c;
			end
		end
		endcase
		cur_addr = a;
		cur_pair = req_narrow && (k == `KIND_FETCH || k == `KIND_PREF);
		req_kind = k;
		req_addr = a;
		req_valid = 1'b1;
		@(negedge clock);
		req_valid = 1'b0;
		n = 0;
		while (!done && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk("done_seen", 32'h1, {31'h0, done});
		@(posedge clock);
		#1;
		chk("beats", 32'(ea.size()), 32'(aq.size()));
		for (int i = 0; i < ea.size() && i < aq.size(); i++) begin
			chk("haddr", ea[i], aq[i][39:8]);
			chk("ctrl", {24'h0, eb[i]}, {24'h0, aq[i][7:0]});
			chk("hwrite", {31'h0, k == `KIND_WRITE || k >= `KIND_WBACK},
				{31'h0, aq[i][40]});
		end
		for (int j = 0; j < wq.size(); j++) begin
			w = (k == `KIND_WBACK) ? 32'(wq[j][36:34]) : 32'(j);
			chk("hwdata", wr_line[32 * w +: 32], wq[j][31:0]);
		end
		c = (k == `KIND_WRITE || k == `KIND_WBACK || k == `KIND_BWRITE) ?
			0 : ea.size();
		chk("rd_beats", 32'(c), 32'(rd_cnt));
		chk("bus_err", 32'h0, {31'h0, bus_err});
		if (k < `KIND_WALK)
			chk("align", {31'h0, s != a}, {31'h0, align_fault});
	endtask : run

	initial begin
		#200000;
		errors++;
		stop_test();
	end

	initial begin
		seed = 32'hd37f;
		errors = 0;
		comparisons = 0;
		{rst_b, ce, req_valid, req_narrow, prefetch_en, dph, dwr} = 7'h0;
		{req_kind, req_size, req_dirty, req_words, wait_len} = 14'h0;
		{req_addr, dad, cur_addr, cur_pair, rd_cnt, wr_line} = '0;
		repeat (4) @(negedge clock);
		chk("rst_state", {27'h1, `TRANS_IDLE, `SIZE_WORD},
			{27'(req_ready), htrans, hsize});
		rst_b = 1'b1;
		// frozen by ce: a waiting request must not start a transfer
		req_valid = 1'b1;
		req_kind = `KIND_FETCH;
		repeat (3) @(negedge clock);
		chk("frozen", {30'h1, `TRANS_IDLE}, {30'(req_ready), htrans});
		req_valid = 1'b0;
		ce = 1'b1;
		for (int i = 0; i < 80; i++) begin
			// new stimulus only on a falling edge, clear of the sampling edge
			@(negedge clock);
			for (int w = 0; w < 8; w++)
				wr_line[32 * w +: 32] = $random(seed);
			req_size = 3'($unsigned($random(seed)) % 3);
			req_words = (i >= 64) ? 4'(i) : 4'($random(seed));
			req_dirty = (i >= 64) ? 2'(i) : 2'($random(seed));
			{req_narrow, prefetch_en, wait_len} = 4'($random(seed));
			run((i >= 64) ? ((i < 68) ? `KIND_WBACK : `KIND_BWRITE) :
				3'(i % 8), $random(seed) & ((i % 8 == 4) ? ~32'h10 : ~32'h0));
		end
		stop_test();
	end
endmodule : core_ahb_bus_interface_test

`default_nettype wire
